// File: logic/spu_pkg.sv
// Purpose: shared constants and types of the serial port block
// Assumes: registers sit at word index times four on a 32-bit bus
// Notes: mode codes follow the two-bit frame mode field
package spu_pkg;

  // data path and buffer geometry
  localparam int unsigned SPU_DATA_W = 8;
  localparam int unsigned SPU_FIFO_DEPTH = 8;

  // register word indices and byte addresses
  localparam logic [7:0] SPU_IDX_PWR = 8'h87;
  localparam logic [7:0] SPU_IDX_CTRL = 8'h98;
  localparam logic [7:0] SPU_IDX_DATA = 8'h99;
  localparam logic [7:0] SPU_IDX_BAUDSRC = 8'h9E;
  localparam logic [9:0] SPU_ADR_PWR = {SPU_IDX_PWR, 2'h0};
  localparam logic [9:0] SPU_ADR_CTRL = {SPU_IDX_CTRL, 2'h0};
  localparam logic [9:0] SPU_ADR_DATA = {SPU_IDX_DATA, 2'h0};
  localparam logic [9:0] SPU_ADR_BAUDSRC = {SPU_IDX_BAUDSRC, 2'h0};

  // uart_control field positions and reset
  localparam int unsigned SPU_CTRL_MODE_HI = 7;
  localparam int unsigned SPU_CTRL_MODE_LO = 6;
  localparam int unsigned SPU_CTRL_AFILT = 5;
  localparam int unsigned SPU_CTRL_RXEN = 4;
  localparam int unsigned SPU_CTRL_TXN = 3;
  localparam int unsigned SPU_CTRL_RXN = 2;
  localparam int unsigned SPU_CTRL_TXD = 1;
  localparam int unsigned SPU_CTRL_RXD = 0;
  localparam logic [7:0] SPU_CTRL_RESET = 8'h00;

  // power_and_baud_control and baud source fields
  localparam int unsigned SPU_PWR_BAUD_DOUBLE = 7;
  localparam int unsigned SPU_SRC_TX_ALT = 0;
  localparam int unsigned SPU_SRC_RX_ALT = 1;

  // frame modes
  localparam logic [1:0] SPU_MODE_SYNC = 2'h0;
  localparam logic [1:0] SPU_MODE_10BIT = 2'h1;
  localparam logic [1:0] SPU_MODE_11FIX = 2'h2;
  localparam logic [1:0] SPU_MODE_11VAR = 2'h3;

  // timing counts in system clocks, oversample ticks or bits
  localparam logic [3:0] SPU_SYNC_DIV_SLOW = 4'hC;
  localparam logic [3:0] SPU_SYNC_DIV_FAST = 4'h4;
  localparam logic [2:0] SPU_FIX_TICK_SLOW = 3'h4;
  localparam logic [2:0] SPU_FIX_TICK_FAST = 3'h2;
  localparam logic [3:0] SPU_OVS_LAST = 4'hF;
  localparam logic [3:0] SPU_SAMPLE_POINT = 4'h7;
  localparam logic [3:0] SPU_SYNC_BITS_LAST = 4'h7;
  localparam logic [3:0] SPU_LAST_BIT_10 = 4'h9;
  localparam logic [3:0] SPU_LAST_BIT_11 = 4'hA;

  typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC_OUT, TX_SYNC_IN} spu_tx_state_t;
  typedef enum logic {RX_IDLE, RX_FRAME} spu_rx_state_t;

endpackage

// File: logic/spu_stream_if.sv
// Purpose: valid/ready word stream between the block's own modules
// Assumes: one clock for both ends
// Notes: a word moves on a clock edge where valid and ready are both high
`timescale 1ns/1ps
interface spu_stream_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: logic/spu_ram.sv
// Purpose: small word store with registered read data
// Assumes: one write port, one read port, same clock
// Notes: a write to the address being read shows up at once on the read side
`timescale 1ns/1ps
module spu_ram #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [$clog2(D)-1:0] wAddr,
  input wire logic [W-1:0] wData,
  input wire logic [$clog2(D)-1:0] rAddr,
  output logic [W-1:0] rData
);
  logic [W-1:0] mem [D];

  // storage array, no reset needed
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[wAddr] <= wData;
    end
  end

  // read register with write bypass so a fresh word is never stale
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rData <= '0;
    end
    else if (we && (wAddr == rAddr))
    begin
      rData <= wData;
    end
    else
    begin
      rData <= mem[rAddr];
    end
  end
endmodule

// File: logic/spu_fifo.sv
// Purpose: first-in first-out buffer with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: output data comes from the ram read register, pointed one ahead on pop
`timescale 1ns/1ps
module spu_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rst,
  spu_stream_if.snk inS,
  spu_stream_if.src outS
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
  } spu_fifo_state_t;

  spu_fifo_state_t s_reg;
  spu_fifo_state_t s_next;
  logic push;
  logic pop;
  logic [AW-1:0] rdAddr;

  // handshakes: full and empty straight from the count
  assign inS.ready = (s_reg.count != (AW + 1)'(D));
  assign outS.valid = (s_reg.count != '0);
  assign push = inS.valid & inS.ready;
  assign pop = outS.valid & outS.ready;
  assign rdAddr = pop ? s_reg.rdPtr + 1'b1 : s_reg.rdPtr;

  // pointer and count update
  always_comb
  begin
    s_next = s_reg;
    if (push)
    begin
      s_next.wrPtr = s_reg.wrPtr + 1'b1;
    end
    if (pop)
    begin
      s_next.rdPtr = s_reg.rdPtr + 1'b1;
    end
    s_next.count = s_reg.count + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  spu_ram #(.W(W), .D(D)) store (
    .clk(clk),
    .rst(rst),
    .we(push),
    .wAddr(s_reg.wrPtr),
    .wData(inS.data),
    .rAddr(rdAddr),
    .rData(outS.data)
  );
endmodule

// File: logic/spu_uart.sv
// Purpose: four-mode serial port with classic Wishbone register access
// Assumes: 100 MHz clk; timer overflow pulses are one clk wide, same clock
// Notes: transmit bytes queue in an 8-word buffer before the shifter
// Operation
// - mode 00: half-duplex sync, data on rx pin, clock on tx pin, 8 bits LSB first
// - mode 01: async frame of start, eight data, stop; variable baud
// - mode 10: async frame of start, eight data, ninth bit, stop; fixed baud
// - mode 11: same eleven-bit frame as mode 10 with variable baud
// - modes 10/11 with address filter set: receive flag only when ninth bit is one
// - reception happens only while the receive enable bit is one
// - modes 10/11 store the received ninth bit in the control register
// - control register holds transmit done flag, the transmit interrupt request
// - control register holds receive done flag, the receive interrupt request
// - data buffer address reaches separate transmit and receive storage
// - writing the data buffer loads the transmitter and starts sending
// - mode 00 shifts at clock/12, or clock/4 with baud doubling
// - mode 10 runs at clock/64, or clock/32 with baud doubling
// - modes 01/11 use timer1 overflow unless an alternate timer2 select is set
`timescale 1ns/1ps
module spu_uart (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic timer1Ovf,
  input wire logic timer2Ovf,
  input wire logic rxPinIn,
  output logic rxPinOut,
  output logic rxPinOe_n,
  output logic txPin,
  output logic txIrqReq,
  output logic rxIrqReq
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic baudDouble;
    logic txAltSrc;
    logic rxAltSrc;
    logic [7:0] rxLatch;
    logic ack;
    logic [31:0] rdData;
    logic t1Half;
    logic [2:0] fixCnt;
    spu_pkg::spu_tx_state_t txState;
    logic [10:0] txShift;
    logic [3:0] txSub;
    logic [3:0] txBit;
    spu_pkg::spu_rx_state_t rxState;
    logic [8:0] rxShift;
    logic [3:0] rxSub;
    logic [3:0] rxBit;
    logic rxSync1;
    logic rxSync2;
    logic rxPrev;
    logic txPin;
    logic rxPinOut;
    logic rxPinOe_n;
  } spu_state_t;

  spu_state_t s_reg;
  spu_state_t s_next;

  spu_stream_if #(.W(spu_pkg::SPU_DATA_W)) txIn ();
  spu_stream_if #(.W(spu_pkg::SPU_DATA_W)) txOut ();

  logic busReq;
  logic [7:0] regIdx;
  logic wrLane;
  logic [1:0] mode;
  logic fixTick;
  logic t1Tick;
  logic txTick;
  logic rxTick;
  logic [3:0] syncLim;
  logic [3:0] syncHalf;
  logic [2:0] fixLim;
  logic popTx;
  logic rxSample;
  logic rxAccept;

  // true for the two eleven-bit frame modes
  function automatic logic isNinthMode(input logic [1:0] m);
    isNinthMode = (m == spu_pkg::SPU_MODE_11FIX) || (m == spu_pkg::SPU_MODE_11VAR);
  endfunction

  // bus request decode
  assign busReq = wb_cyc_i & wb_stb_i & ~s_reg.ack;
  assign regIdx = wb_adr_i[9:2];
  assign wrLane = busReq & wb_we_i & wb_sel_i[0];
  assign mode = s_reg.ctrl[spu_pkg::SPU_CTRL_MODE_HI:spu_pkg::SPU_CTRL_MODE_LO];

  // data buffer writes go into the transmit queue, never the receive latch
  assign txIn.valid = wrLane & (regIdx == spu_pkg::SPU_IDX_DATA);
  assign txIn.data = wb_dat_i[7:0];
  assign txOut.ready = popTx;

  // baud sources: fixed divider, timer1 halved unless doubled, or timer2
  assign syncLim = s_reg.baudDouble ? spu_pkg::SPU_SYNC_DIV_FAST : spu_pkg::SPU_SYNC_DIV_SLOW;
  assign syncHalf = syncLim >> 1;
  assign fixLim = s_reg.baudDouble ? spu_pkg::SPU_FIX_TICK_FAST : spu_pkg::SPU_FIX_TICK_SLOW;
  assign fixTick = (s_reg.fixCnt == fixLim - 3'h1);
  assign t1Tick = timer1Ovf & (s_reg.baudDouble | s_reg.t1Half);
  assign txTick = (mode == spu_pkg::SPU_MODE_11FIX) ? fixTick
                : (s_reg.txAltSrc ? timer2Ovf : t1Tick);
  assign rxTick = (mode == spu_pkg::SPU_MODE_11FIX) ? fixTick
                : (s_reg.rxAltSrc ? timer2Ovf : t1Tick);
  assign rxSample = s_reg.rxSync2;

  // next-state logic of bus slave, transmitter and receiver
  always_comb
  begin
    s_next = s_reg;
    popTx = 1'b0;
    rxAccept = 1'b0;
    s_next.rxSync1 = rxPinIn;
    s_next.rxSync2 = s_reg.rxSync1;
    s_next.rxPrev = s_reg.rxSync2;

    // dividers for the fixed-rate mode and timer1 halving
    s_next.fixCnt = fixTick ? 3'h0 : s_reg.fixCnt + 3'h1;
    if (timer1Ovf)
    begin
      s_next.t1Half = ~s_reg.t1Half;
    end

    // ack one cycle after the request; data writes wait for queue room
    s_next.ack = busReq & (~txIn.valid | txIn.ready);
    if (busReq && !wb_we_i)
    begin
      case (regIdx)
        spu_pkg::SPU_IDX_CTRL: s_next.rdData = {24'h000000, s_reg.ctrl};
        spu_pkg::SPU_IDX_DATA: s_next.rdData = {24'h000000, s_reg.rxLatch};
        spu_pkg::SPU_IDX_BAUDSRC: s_next.rdData = {30'h0, s_reg.rxAltSrc, s_reg.txAltSrc};
        default: s_next.rdData = 32'h00000000;
      endcase
    end
    if (wrLane)
    begin
      case (regIdx)
        spu_pkg::SPU_IDX_CTRL: s_next.ctrl = wb_dat_i[7:0];
        spu_pkg::SPU_IDX_PWR: s_next.baudDouble = wb_dat_i[spu_pkg::SPU_PWR_BAUD_DOUBLE];
        spu_pkg::SPU_IDX_BAUDSRC:
        begin
          s_next.txAltSrc = wb_dat_i[spu_pkg::SPU_SRC_TX_ALT];
          s_next.rxAltSrc = wb_dat_i[spu_pkg::SPU_SRC_RX_ALT];
        end
        default: s_next.ctrl = s_next.ctrl;
      endcase
    end

    // transmitter, which also runs both directions of the sync mode
    case (s_reg.txState)
      spu_pkg::TX_IDLE:
      begin
        s_next.txSub = 4'h0;
        s_next.txBit = 4'h0;
        if (txOut.valid)
        begin
          popTx = 1'b1;
          if (mode == spu_pkg::SPU_MODE_SYNC)
          begin
            s_next.txShift = {3'h7, txOut.data};
            s_next.txState = spu_pkg::TX_SYNC_OUT;
          end
          else
          begin
            s_next.txShift = {1'b1,
                              isNinthMode(mode) ? s_reg.ctrl[spu_pkg::SPU_CTRL_TXN] : 1'b1,
                              txOut.data, 1'b0};
            s_next.txState = spu_pkg::TX_ASYNC;
          end
        end
        else if ((mode == spu_pkg::SPU_MODE_SYNC) && s_reg.ctrl[spu_pkg::SPU_CTRL_RXEN]
                 && !s_reg.ctrl[spu_pkg::SPU_CTRL_RXD])
        begin
          s_next.txState = spu_pkg::TX_SYNC_IN;
        end
      end
      spu_pkg::TX_ASYNC:
      begin
        if (txTick)
        begin
          s_next.txSub = s_reg.txSub + 4'h1;
          if (s_reg.txSub == spu_pkg::SPU_OVS_LAST)
          begin
            s_next.txShift = {1'b1, s_reg.txShift[10:1]};
            s_next.txBit = s_reg.txBit + 4'h1;
            if (s_reg.txBit == (isNinthMode(mode) ? spu_pkg::SPU_LAST_BIT_11
                                                  : spu_pkg::SPU_LAST_BIT_10))
            begin
              s_next.txState = spu_pkg::TX_IDLE;
              s_next.ctrl[spu_pkg::SPU_CTRL_TXD] = 1'b1;
            end
          end
        end
      end
      spu_pkg::TX_SYNC_OUT, spu_pkg::TX_SYNC_IN:
      begin
        s_next.txSub = s_reg.txSub + 4'h1;
        // receive samples as the shift clock rises at mid bit
        if ((s_reg.txState == spu_pkg::TX_SYNC_IN) && (s_reg.txSub == syncHalf - 4'h1))
        begin
          s_next.txShift[7:0] = {rxSample, s_reg.txShift[7:1]};
        end
        if (s_reg.txSub == syncLim - 4'h1)
        begin
          s_next.txSub = 4'h0;
          s_next.txBit = s_reg.txBit + 4'h1;
          if (s_reg.txState == spu_pkg::TX_SYNC_OUT)
          begin
            s_next.txShift = {1'b1, s_reg.txShift[10:1]};
          end
          if (s_reg.txBit == spu_pkg::SPU_SYNC_BITS_LAST)
          begin
            s_next.txState = spu_pkg::TX_IDLE;
            if (s_reg.txState == spu_pkg::TX_SYNC_OUT)
            begin
              s_next.ctrl[spu_pkg::SPU_CTRL_TXD] = 1'b1;
            end
            else
            begin
              s_next.rxLatch = s_reg.txShift[7:0];
              s_next.ctrl[spu_pkg::SPU_CTRL_RXD] = 1'b1;
            end
          end
        end
      end
      default: s_next.txState = spu_pkg::TX_IDLE;
    endcase

    // asynchronous receiver with 16x oversampling, mid-bit sample
    case (s_reg.rxState)
      spu_pkg::RX_IDLE:
      begin
        s_next.rxSub = 4'h0;
        s_next.rxBit = 4'h0;
        if ((mode != spu_pkg::SPU_MODE_SYNC) && s_reg.ctrl[spu_pkg::SPU_CTRL_RXEN]
            && s_reg.rxPrev && !s_reg.rxSync2)
        begin
          s_next.rxState = spu_pkg::RX_FRAME;
        end
      end
      spu_pkg::RX_FRAME:
      begin
        if (rxTick)
        begin
          s_next.rxSub = s_reg.rxSub + 4'h1;
          if (s_reg.rxSub == spu_pkg::SPU_SAMPLE_POINT)
          begin
            s_next.rxBit = s_reg.rxBit + 4'h1;
            if ((s_reg.rxBit == 4'h0) && rxSample)
            begin
              s_next.rxState = spu_pkg::RX_IDLE; // glitch, not a start bit
            end
            else if (s_reg.rxBit == (isNinthMode(mode) ? spu_pkg::SPU_LAST_BIT_11
                                                       : spu_pkg::SPU_LAST_BIT_10))
            begin
              s_next.rxState = spu_pkg::RX_IDLE;
              rxAccept = !s_reg.ctrl[spu_pkg::SPU_CTRL_RXD]
                         && (!isNinthMode(mode) || !s_reg.ctrl[spu_pkg::SPU_CTRL_AFILT]
                             || s_reg.rxShift[8]);
            end
            else if (s_reg.rxBit != 4'h0)
            begin
              s_next.rxShift = {rxSample, s_reg.rxShift[8:1]};
            end
          end
        end
      end
      default: s_next.rxState = spu_pkg::RX_IDLE;
    endcase

    // frame accepted: latch byte, ninth bit, raise the flag
    if (rxAccept)
    begin
      if (isNinthMode(mode))
      begin
        s_next.rxLatch = s_reg.rxShift[7:0];
        s_next.ctrl[spu_pkg::SPU_CTRL_RXN] = s_reg.rxShift[8];
      end
      else
      begin
        s_next.rxLatch = s_reg.rxShift[8:1];
      end
      s_next.ctrl[spu_pkg::SPU_CTRL_RXD] = 1'b1;
    end

    // pin drivers: sync transmit drives both pins, sync receive and async drive tx only
    case (s_next.txState)
      spu_pkg::TX_ASYNC:
      begin
        s_next.txPin = s_next.txShift[0];
        s_next.rxPinOut = 1'b1;
        s_next.rxPinOe_n = 1'b1;
      end
      spu_pkg::TX_SYNC_OUT:
      begin
        s_next.txPin = (s_next.txSub >= syncHalf);
        s_next.rxPinOut = s_next.txShift[0];
        s_next.rxPinOe_n = 1'b0;
      end
      spu_pkg::TX_SYNC_IN:
      begin
        s_next.txPin = (s_next.txSub >= syncHalf);
        s_next.rxPinOut = 1'b1;
        s_next.rxPinOe_n = 1'b1;
      end
      default:
      begin
        s_next.txPin = 1'b1;
        s_next.rxPinOut = 1'b1;
        s_next.rxPinOe_n = 1'b1;
      end
    endcase
  end

  // state register; idle line levels are high
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_reg <= '0;
      s_reg.ctrl <= spu_pkg::SPU_CTRL_RESET;
      s_reg.rxSync1 <= 1'b1;
      s_reg.rxSync2 <= 1'b1;
      s_reg.rxPrev <= 1'b1;
      s_reg.txPin <= 1'b1;
      s_reg.rxPinOut <= 1'b1;
      s_reg.rxPinOe_n <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flip-flops
  assign wb_dat_o = s_reg.rdData;
  assign wb_ack_o = s_reg.ack;
  assign txPin = s_reg.txPin;
  assign rxPinOut = s_reg.rxPinOut;
  assign rxPinOe_n = s_reg.rxPinOe_n;
  assign txIrqReq = s_reg.ctrl[spu_pkg::SPU_CTRL_TXD];
  assign rxIrqReq = s_reg.ctrl[spu_pkg::SPU_CTRL_RXD];

  spu_fifo #(.W(spu_pkg::SPU_DATA_W), .D(spu_pkg::SPU_FIFO_DEPTH)) txQueue (
    .clk(clk),
    .rst(rst),
    .inS(txIn),
    .outS(txOut)
  );
endmodule

// File: tb/spu_uart_asserts.sv
// Purpose: pin-level checks of the serial port's bus answers and flags
// Assumes: one clock, reset asynchronous and active high
// Notes: bound to every spu_uart instance
`timescale 1ns/1ps
module spu_uart_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic txPin,
  input wire logic rxPinOe_n,
  input wire logic txIrqReq,
  input wire logic rxIrqReq
);
  logic req;
  logic ctrlWr;
  logic mapped;
  // request, control write and address decode seen at the pins
  assign req = wb_cyc_i && wb_stb_i;
  assign ctrlWr = req && wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == spu_pkg::SPU_IDX_CTRL;
  assign mapped = wb_adr_i[9:2] inside {spu_pkg::SPU_IDX_PWR, spu_pkg::SPU_IDX_CTRL,
    spu_pkg::SPU_IDX_DATA, spu_pkg::SPU_IDX_BAUDSRC};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // a read answered at one word index
  sequence rd_ack_s(logic [7:0] idx);
    wb_ack_o && !wb_we_i && wb_adr_i[9:2] == idx;
  endsequence
  // a request the design must answer at once
  sequence quick_req_s;
    req && !wb_ack_o && !(wb_we_i && wb_adr_i[9:2] == spu_pkg::SPU_IDX_DATA);
  endsequence
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  ack_prompt_a: assert property (quick_req_s |=> wb_ack_o)
    else $error("register access not answered next cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(req))
    else $error("ack without a request");
  upper_zero_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper lanes not zero");
  pwr_read_a: assert property (rd_ack_s(spu_pkg::SPU_IDX_PWR) |-> wb_dat_o == 32'h0)
    else $error("write-only register read back nonzero");
  unmapped_read_a: assert property (wb_ack_o && !wb_we_i && !mapped |-> wb_dat_o == 32'h0)
    else $error("unmapped read returned data");
  tx_flag_hold_a: assert property (txIrqReq && !ctrlWr && !$past(ctrlWr) |=> txIrqReq)
    else $error("transmit flag dropped without software");
  rx_flag_hold_a: assert property (rxIrqReq && !ctrlWr && !$past(ctrlWr) |=> rxIrqReq)
    else $error("receive flag dropped without software");
  sync_low_a: assert property ($fell(txPin) && !rxPinOe_n |-> !txPin [*2])
    else $error("shift clock low phase too short");
endmodule
bind spu_uart spu_uart_asserts u_chk (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txPin(txPin), .rxPinOe_n(rxPinOe_n),
  .txIrqReq(txIrqReq), .rxIrqReq(rxIrqReq));

// File: tb/spu_remote_model.sv
// Purpose: remote serial device on the far side of the port's pins
// Assumes: its line idles high through a pull-up
// Notes: bit times are handed in as system clock counts
`timescale 1ns/1ps
module spu_remote_model (
  input wire logic clk,
  input wire logic txPin,
  input wire logic rxLine,
  output logic drive
);
  initial drive = 1'b1;

  // start, nine data bits lsb first, then stop
  task automatic send(input int bitClk, input logic [8:0] d);
    for (int i = 0; i < 11; i++)
    begin
      drive <= (i == 0) ? 1'b0 : (i == 10) ? 1'b1 : d[i - 1];
      repeat (bitClk) @(posedge clk);
    end
  endtask

  // sample an async frame at mid bit, start bit into bit 0
  task automatic take(input int bitClk, input int nb, output logic [10:0] f);
    int n;
    n = 0;
    f = '1;
    while (txPin !== 1'b0 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    repeat (bitClk / 2) @(posedge clk);
    for (int i = 0; i < nb; i++)
    begin
      f[i] = txPin;
      if (i < nb - 1)
        repeat (bitClk) @(posedge clk);
    end
  endtask

  // capture a sync byte at each rise of the shift clock
  task automatic take_sync(output logic [7:0] d, output int per);
    int n;
    int t0;
    int i;
    logic last;
    n = 0;
    t0 = 0;
    i = 0;
    d = '0;
    per = 0;
    last = txPin;
    while (i < 8 && n < 20000)
    begin
      @(posedge clk);
      n++;
      if (txPin === 1'b1 && last === 1'b0)
      begin
        d[i] = rxLine;
        per = n - t0;
        t0 = n;
        i++;
      end
      last = txPin;
    end
  endtask

  // shift a byte towards the port, next bit just after each rise of its clock
  task automatic give_sync(input logic [7:0] d);
    int n;
    int i;
    logic last;
    n = 0;
    i = 1;
    last = txPin;
    drive <= d[0];
    while (i < 9 && n < 2000)
    begin
      @(posedge clk);
      n++;
      if (txPin === 1'b1 && last === 1'b0)
      begin
        drive <= (i < 8) ? d[i] : 1'b1;
        i++;
      end
      last = txPin;
    end
  endtask
endmodule

// File: tb/spu_uart_tb_top.sv
// Purpose: self-checking bench of the serial port block
// Assumes: 100 MHz clock; the far line idles high
// Notes: both timers overflow every second clock
`timescale 1ns/1ps
module spu_uart_tb_top;
  localparam logic [9:0] PWR = spu_pkg::SPU_ADR_PWR;
  localparam logic [9:0] CTRL = spu_pkg::SPU_ADR_CTRL;
  localparam logic [9:0] DATA = spu_pkg::SPU_ADR_DATA;
  localparam logic [9:0] SRC = spu_pkg::SPU_ADR_BAUDSRC;
  logic clk, rst, cyc, stb, we, t1Ovf, t2Ovf, ack, rxOut, rxOe_n, txPin, txIrq, rxIrq, farDrive;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] datI, datO, e;
  logic [7:0] q, sb;
  logic [10:0] f;
  logic [35:0] r;
  int miscompares, samples_checked, n, per;
  wire logic rxLine;
  // table: baud double, baud source, control, bit time in clocks
  logic [31:0] txTab [4] = '{32'h0000_8840, 32'h8000_8820, 32'h0000_4040, 32'h0001_C020};
  // table: ninth bit, control, control after, latch after, data sent
  logic [35:0] rxTab [4] = '{36'h1_9095_3C3C, 36'h0_B0B0_3C55, 36'h1_B0B5_6666,
    36'h1_8080_6677};
  // the port drives its receive pin only when enabled low
  assign rxLine = rxOe_n ? farDrive : rxOut;

  spu_uart uut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
    .timer1Ovf(t1Ovf), .timer2Ovf(t2Ovf), .rxPinIn(rxLine), .rxPinOut(rxOut),
    .rxPinOe_n(rxOe_n), .txPin(txPin), .txIrqReq(txIrq), .rxIrqReq(rxIrq));
  spu_remote_model remote (.clk(clk), .txPin(txPin), .rxLine(rxLine), .drive(farDrive));

  // clock and one-clock timer overflow pulses
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    t1Ovf <= !t1Ovf;
    t2Ovf <= !t2Ovf;
  end

  task automatic finish_test;
    if (miscompares == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x)
    begin
      $display("unexpected %s expected %0h seen %0h", nm, x, g);
      miscompares++;
    end
  endtask

  // one classic cycle; called just after an edge, ends after the idle cycle
  task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datI <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 3000);
    q = datO[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 3000)
    begin
      miscompares++;
      finish_test();
    end
    @(posedge clk);
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] x, input string nm);
    wb(1'b0, a, 8'h00);
    chk(nm, {24'h0, x}, {24'h0, q});
  endtask

  task automatic wait_tx;
    n = 0;
    while (txIrq !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    chk("txIrq", 32'h1, {31'h0, txIrq});
    if (txIrq !== 1'b1)
      finish_test();
  endtask

  // main sequence
  initial
  begin
    rst = 1'b1;
    {cyc, stb, we, t1Ovf, t2Ovf} = 5'h00;
    adr = 10'h000;
    sel = 4'hF;
    datI = 32'h0;
    miscompares = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(CTRL, 8'h00, "control");
    rd(DATA, 8'h00, "rxLatch");
    rd(PWR, 8'h00, "power");
    rd(10'h3FC, 8'h00, "unmapped");
    wb(1'b1, CTRL, 8'hAF);
    rd(CTRL, 8'hAF, "control");
    // async transmit in every frame mode and baud source
    for (int k = 0; k < 4; k++)
    begin
      e = txTab[k];
      wb(1'b1, PWR, e[31:24]);
      wb(1'b1, SRC, e[23:16]);
      wb(1'b1, CTRL, e[15:8]);
      fork
        remote.take(int'(e[7:0]), e[15] ? 11 : 10, f);
        wb(1'b1, DATA, 8'hA5);
      join
      chk("frame", {21'h0, 1'b1, e[15] ? e[11] : 1'b1, 8'hA5, 1'b0}, {21'h0, f});
      wait_tx();
      rd(CTRL, e[15:8] | 8'h02, "control");
    end
    rd(DATA, 8'h00, "rxLatch");
    // mode 2 reception with filter and enable cases
    for (int k = 0; k < 4; k++)
    begin
      r = rxTab[k];
      wb(1'b1, CTRL, r[31:24]);
      remote.send(64, {r[32], r[7:0]});
      rd(CTRL, r[23:16], "control");
      chk("rxIrq", {31'h0, r[16]}, {31'h0, rxIrq});
      rd(DATA, r[15:8], "rxLatch");
    end
    // sync shift mode at both rates
    for (int b = 0; b < 2; b++)
    begin
      wb(1'b1, PWR, {b[0], 7'h00});
      wb(1'b1, CTRL, 8'h00);
      fork
        remote.take_sync(sb, per);
        wb(1'b1, DATA, 8'h96);
      join
      chk("syncByte", 32'h96, {24'h0, sb});
      chk("syncBit", b[0] ? 32'h4 : 32'hC, per);
      wait_tx();
    end
    // sync shift mode reception from the far side
    fork
      remote.give_sync(8'h5A);
      wb(1'b1, CTRL, 8'h10);
    join
    n = 0;
    while (rxIrq !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    rd(CTRL, 8'h11, "control");
    if (rxIrq !== 1'b1)
      finish_test();
    rd(DATA, 8'h5A, "rxLatch");
    // fill the queue until a write stalls, then drain it in order
    wb(1'b1, PWR, 8'h80);
    wb(1'b1, CTRL, 8'h80);
    fork
      for (int k = 0; k < 10; k++)
      begin
        wb(1'b1, DATA, 8'h40 + k[7:0]);
        if (k < 9)
          chk("ackWait", 32'h2, n);
        else
          chk("stall", 32'h1, {31'h0, n > 2});
      end
      for (int j = 0; j < 10; j++)
      begin
        remote.take(32, 11, f);
        chk("frame", {21'h0, 2'h2, 8'h40 + j[7:0], 1'b0}, {21'h0, f});
      end
    join
    finish_test();
  end
endmodule
